//--- src/oscsd_core.sv
// Oscillator control and clock divider registers with unlock protection.
// Assumes the register port is on clk_sys; the option and status inputs are synchronised to it.
//
// Contract
// - Watchdog oscillator runs only while its enable bit is 1.
// - Primary failure clears the primary failure enable bit.
// - Primary failure enable gates both detection and recovery.
// - Watchdog failure clears the watchdog failure enable bit.
// - Watchdog failure monitoring runs only while its enable is 1.
// - Flash low-power: flash off when idle, on during reads.
// - Flash low-power reset value comes from the option bit.
// - Select 00 picks the internal precision oscillator.
// - Select 01 picks the crystal or external clock.
// - Select 11 picks the watchdog oscillator; 10 reserved.
// - Divider writes are accepted only when unlocked.
// - Writing E7h then 18h to the control address unlocks.
// - Divider write relocks the registers.
// - Divider 00h disables division; else divide by value.
// - Control register needs unlock too and relocks after a write.
// - Flash low-power resets to 1 when option bit is 0.
// - Watchdog failure declared after 8000 cycles without its clock.
`default_nettype none
module oscsd_core
    import oscsd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [23:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // Option and status pins
    input wire logic lowPowerOptionBit,
    input wire logic primaryOscFail,
    input wire logic watchdogClkIn,
    input wire logic flashRead,
    input wire logic clockIdle,
    // Clock controls
    output logic ipoEnable,
    output logic xtalEnable,
    output logic watchdogOscRun,
    output logic primaryRecoveryEnable,
    output logic [1:0] clockSourceSelect,
    output logic flashPowerUp,
    output logic watchdogFailEvent,
    output logic sysClkDivEn,
    output logic sysClkTick
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [1:0] optSync_reg;
    logic [1:0] pofSync_reg;
    logic [1:0] wdcSync_reg;
    logic [1:0] frdSync_reg;
    logic [1:0] idlSync_reg;
    logic wdcLast_reg;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            optSync_reg <= 2'h0;
            pofSync_reg <= 2'h0;
            wdcSync_reg <= 2'h0;
            frdSync_reg <= 2'h0;
            idlSync_reg <= 2'h0;
            wdcLast_reg <= 1'b0;
        end else begin
            optSync_reg <= {optSync_reg[0], lowPowerOptionBit};
            pofSync_reg <= {pofSync_reg[0], primaryOscFail};
            wdcSync_reg <= {wdcSync_reg[0], watchdogClkIn};
            frdSync_reg <= {frdSync_reg[0], flashRead};
            idlSync_reg <= {idlSync_reg[0], clockIdle};
            wdcLast_reg <= wdcSync_reg[1];
        end
    end
    logic optBit;
    logic pofDetect;
    logic wdcEdge;
    assign optBit = optSync_reg[1];
    assign wdcEdge = wdcSync_reg[1] ^ wdcLast_reg;

    // ----------------------------------------
    // Strap capture after reset release
    // ----------------------------------------
    // Option bit trusted only once both synchroniser stages hold it
    logic [1:0] strapArm_reg;
    logic strapDone_reg;
    logic strapLoad;
    assign strapLoad = strapArm_reg[1] && !strapDone_reg;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strapArm_reg <= 2'h0;
        end else begin
            strapArm_reg <= {strapArm_reg[0], 1'b1};
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strapDone_reg <= 1'b0;
        end else if (strapLoad) begin
            strapDone_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // Unlock sequencer
    // ----------------------------------------
    oscsd_lock_t lock_reg;
    oscsd_lock_t lock_next;
    logic ctlHit;
    logic divHit;
    logic ctlWrite;
    logic divWrite;
    always_comb begin
        ctlHit = 1'b0;
        divHit = 1'b0;
        if (regAddr == ADDR_OSC_CTL) begin
            ctlHit = 1'b1;
        end else if (regAddr == ADDR_CLK_DIV) begin
            divHit = 1'b1;
        end
    end
    assign ctlWrite = regWrEn && ctlHit && lock_reg == LK_OPEN;
    assign divWrite = regWrEn && divHit && lock_reg == LK_OPEN;
    always_comb begin
        lock_next = lock_reg;
        if (regWrEn) begin
            case (lock_reg)
                LK_LOCKED: begin
                    lock_next = (ctlHit && regWrData == UNLOCK_KEY1) ? LK_HALF : LK_LOCKED;
                end
                LK_HALF: begin
                    lock_next = (ctlHit && regWrData == UNLOCK_KEY2) ? LK_OPEN : LK_LOCKED;
                end
                LK_OPEN: begin
                    lock_next = LK_LOCKED;
                end
                default: begin
                    lock_next = LK_LOCKED;
                end
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock_reg <= LK_LOCKED;
        end else begin
            lock_reg <= lock_next;
        end
    end

    // ----------------------------------------
    // Oscillator control register
    // ----------------------------------------
    logic [7:0] ctl_reg;
    logic wdfDetect;
    assign pofDetect = pofSync_reg[1] && ctl_reg[BIT_POF_EN];
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl_reg <= CTL_RESET;
        end else begin
            if (ctlWrite) begin
                ctl_reg <= regWrData;
            end
            if (strapLoad) begin
                ctl_reg[BIT_FLP_EN] <= !optBit;
            end
            if (pofDetect) begin
                ctl_reg[BIT_POF_EN] <= 1'b0;
            end
            if (wdfDetect) begin
                ctl_reg[BIT_WDF_EN] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Watchdog oscillator failure counter
    // ----------------------------------------
    logic [12:0] wdfCount_reg;
    assign wdfDetect = ctl_reg[BIT_WDF_EN] && !wdcEdge
        && wdfCount_reg == 13'(WDF_CYCLES - 1);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wdfCount_reg <= 13'h0000;
        end else if (!ctl_reg[BIT_WDF_EN] || wdcEdge || wdfDetect) begin
            wdfCount_reg <= 13'h0000;
        end else begin
            wdfCount_reg <= wdfCount_reg + 13'h0001;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            watchdogFailEvent <= 1'b0;
        end else begin
            watchdogFailEvent <= wdfDetect;
        end
    end

    // ----------------------------------------
    // Clock divider register and divider
    // ----------------------------------------
    logic [7:0] div_reg;
    logic [7:0] divCount_reg;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= DIV_RESET;
        end else if (divWrite) begin
            div_reg <= regWrData;
        end else if (strapLoad) begin
            div_reg <= optBit ? DIV_RESET : DIV_RESET_LP;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            divCount_reg <= 8'h00;
        end else if (div_reg == 8'h00 || divCount_reg >= div_reg - 8'h01) begin
            divCount_reg <= 8'h00;
        end else begin
            divCount_reg <= divCount_reg + 8'h01;
        end
    end
    assign sysClkDivEn = div_reg != 8'h00;
    assign sysClkTick = div_reg == 8'h00 || divCount_reg == 8'h00;

    // ----------------------------------------
    // Control outputs
    // ----------------------------------------
    assign ipoEnable = ctl_reg[BIT_IPO_EN];
    assign xtalEnable = ctl_reg[BIT_XTAL_EN];
    assign watchdogOscRun = ctl_reg[BIT_WDO_EN];
    assign primaryRecoveryEnable = ctl_reg[BIT_POF_EN];
    assign clockSourceSelect = ctl_reg[1:0];
    assign flashPowerUp = !ctl_reg[BIT_FLP_EN] || frdSync_reg[1] || !idlSync_reg[1];

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else if (regRdEn && ctlHit) begin
            regRdData <= ctl_reg;
        end else if (regRdEn && divHit) begin
            regRdData <= div_reg;
        end else begin
            regRdData <= 8'h00;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence s_key1;
        regWrEn && ctlHit && regWrData == UNLOCK_KEY1 && lock_reg == LK_LOCKED;
    endsequence
    sequence s_key2;
        regWrEn && ctlHit && regWrData == UNLOCK_KEY2;
    endsequence
    sequence s_open_write;
        regWrEn && lock_reg == LK_OPEN;
    endsequence
    sequence s_half_break;
        regWrEn && lock_reg == LK_HALF && !(ctlHit && regWrData == UNLOCK_KEY2);
    endsequence
    a_unlock_sequence: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_key1 ##1 s_key2 |=> lock_reg == LK_OPEN)
        else $error("unlock sequence not honoured");
    a_ctl_locked_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regWrEn && ctlHit && lock_reg != LK_OPEN && !pofDetect && !wdfDetect && !strapLoad
        |=> ctl_reg == $past(ctl_reg))
        else $error("locked control write took effect");
    a_div_locked_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regWrEn && divHit && lock_reg != LK_OPEN && !strapLoad |=> $stable(div_reg))
        else $error("locked divider write took effect");
    a_div_relock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        divWrite |=> lock_reg == LK_LOCKED && div_reg == $past(regWrData))
        else $error("divider write did not land and relock");
    a_pof_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pofSync_reg[1] && ctl_reg[BIT_POF_EN] |=> !ctl_reg[BIT_POF_EN])
        else $error("primary failure enable not cleared");
    a_wdf_window: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wdfDetect |-> wdfCount_reg == 13'(WDF_CYCLES - 1) ##1 !ctl_reg[BIT_WDF_EN] && watchdogFailEvent)
        else $error("watchdog failure timing wrong");
    a_wdf_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctl_reg[BIT_WDF_EN] |=> wdfCount_reg == 13'h0000)
        else $error("watchdog monitor ran while disabled");
    a_flash_read_up: assert property (@(posedge clk_sys) disable iff (!rst_n)
        frdSync_reg[1] |-> flashPowerUp)
        else $error("flash not powered for read");
    a_strap_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        strapLoad |=> ctl_reg[BIT_FLP_EN] == !$past(optBit)
            && div_reg == ($past(optBit) ? DIV_RESET : DIV_RESET_LP))
        else $error("strap reset values wrong");
    a_unlock_first_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_key1 |=> lock_reg == LK_HALF)
        else $error("first unlock key not taken");
    a_broken_sequence: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_half_break |=> lock_reg == LK_LOCKED)
        else $error("broken unlock sequence did not restart");
    a_open_one_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_open_write |=> lock_reg == LK_LOCKED)
        else $error("registers stayed open after a write");
    a_lock_onehot: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $onehot(lock_reg))
        else $error("lock state not one-hot");
    a_ctl_relock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctlWrite && !pofDetect && !wdfDetect && !strapLoad
        |=> lock_reg == LK_LOCKED && ctl_reg == $past(regWrData))
        else $error("control write did not land and relock");
    a_ctl_no_spurious: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctlWrite && !strapLoad && !pofDetect && !wdfDetect |=> $stable(ctl_reg))
        else $error("control register changed with no cause");
    a_div_no_spurious: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !divWrite && !strapLoad |=> $stable(div_reg))
        else $error("divider changed with no cause");
    a_wdo_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctlWrite |=> watchdogOscRun == $past(regWrData[BIT_WDO_EN]))
        else $error("watchdog oscillator run does not follow its bit");
    a_source_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctlWrite |=> clockSourceSelect == $past(regWrData[1:0]))
        else $error("clock source select does not follow its field");
    a_wdf_count_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctl_reg[BIT_WDF_EN] && !wdcEdge && !wdfDetect
        |=> wdfCount_reg == $past(wdfCount_reg) + 13'h0001)
        else $error("watchdog failure counter did not advance");
    a_wdc_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wdcEdge |=> wdfCount_reg == 13'h0000)
        else $error("watchdog clock seen but counter kept running");
    a_wdf_event_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        watchdogFailEvent |=> !watchdogFailEvent)
        else $error("watchdog failure event longer than one cycle");
    a_div_count_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
        div_reg != 8'h00 && $stable(div_reg) |-> divCount_reg < div_reg)
        else $error("divider counter out of range");
    a_flash_idle_down: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctl_reg[BIT_FLP_EN] && idlSync_reg[1] && !frdSync_reg[1] |-> !flashPowerUp)
        else $error("flash powered while idle in low-power mode");
endmodule : oscsd_core
`default_nettype wire

//--- shared/oscsd_pkg.sv
// Constants for the oscillator select and divider block.
// Assumes a single 100 MHz system clock domain.
`default_nettype none
package oscsd_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [23:0] ADDR_OSC_CTL = 24'hFF_E0A0;
    localparam logic [23:0] ADDR_CLK_DIV = 24'hFF_E0A1;
    // ----------------------------------------
    // Control field positions
    // ----------------------------------------
    localparam int BIT_IPO_EN = 7;
    localparam int BIT_XTAL_EN = 6;
    localparam int BIT_WDO_EN = 5;
    localparam int BIT_POF_EN = 4;
    localparam int BIT_WDF_EN = 3;
    localparam int BIT_FLP_EN = 2;
    // ----------------------------------------
    // Reset values and unlock keys
    // ----------------------------------------
    localparam logic [7:0] CTL_RESET = 8'hA0;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [7:0] DIV_RESET_LP = 8'h08;
    localparam logic [7:0] UNLOCK_KEY1 = 8'hE7;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h18;
    // ----------------------------------------
    // Clock source codes
    // ----------------------------------------
    localparam logic [1:0] SRC_IPO = 2'h0;
    localparam logic [1:0] SRC_XTAL = 2'h1;
    localparam logic [1:0] SRC_WDO = 2'h3;
    // ----------------------------------------
    // Watchdog failure window in system clocks
    // ----------------------------------------
    localparam int WDF_CYCLES = 8000;
    typedef enum logic [2:0] {
        LK_LOCKED = 3'b001,
        LK_HALF = 3'b010,
        LK_OPEN = 3'b100
    } oscsd_lock_t;
endpackage : oscsd_pkg
`default_nettype wire

//--- verification/oscsd_core_tb_top.sv
// Self-checking testbench for the oscillator select and divider core.
// Assumes a 100 MHz clk_sys; the bench drives every core input itself.
`default_nettype none
module oscsd_core_tb_top
    import oscsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [23:0] regAddr = 24'h00_0000;
    logic [7:0] regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regRdData;
    logic lowPowerOptionBit = 1'b1;
    logic primaryOscFail = 1'b0;
    logic watchdogClkIn = 1'b0;
    logic flashRead = 1'b0;
    logic clockIdle = 1'b0;
    logic ipoEnable, xtalEnable, watchdogOscRun, primaryRecoveryEnable;
    logic [1:0] clockSourceSelect;
    logic flashPowerUp, watchdogFailEvent, sysClkDivEn, sysClkTick;
    int mismatches = 0;
    int tests_run = 0;

    always #5 clk_sys = ~clk_sys;

    oscsd_core i_oscsd_core (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData),
        .lowPowerOptionBit(lowPowerOptionBit), .primaryOscFail(primaryOscFail),
        .watchdogClkIn(watchdogClkIn), .flashRead(flashRead), .clockIdle(clockIdle),
        .ipoEnable(ipoEnable), .xtalEnable(xtalEnable), .watchdogOscRun(watchdogOscRun),
        .primaryRecoveryEnable(primaryRecoveryEnable),
        .clockSourceSelect(clockSourceSelect), .flashPowerUp(flashPowerUp),
        .watchdogFailEvent(watchdogFailEvent), .sysClkDivEn(sysClkDivEn),
        .sysClkTick(sysClkTick)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
    endtask : wr

    task automatic rd(input logic [23:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1;
        chk(16'(regRdData), 16'(exp));
    endtask : rd

    task automatic unlock();
        @(posedge clk_sys);
        regAddr <= ADDR_OSC_CTL;
        regWrData <= UNLOCK_KEY1;
        regWrEn <= 1'b1;
        @(posedge clk_sys);
        regWrData <= UNLOCK_KEY2;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
    endtask : unlock

    task automatic ticks(input int cycles, input int expN);
        int n;
        n = 0;
        repeat (cycles) begin
            @(posedge clk_sys);
            #1;
            if (sysClkTick === 1'b1) n++;
        end
        chk(16'(n), 16'(expN));
    endtask : ticks

    task automatic fl(input logic idle, input logic rdv, input logic exp);
        @(posedge clk_sys);
        clockIdle <= idle;
        flashRead <= rdv;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(16'(flashPowerUp), 16'(exp));
    endtask : fl

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic scn_reset_values(input logic opt);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        lowPowerOptionBit <= opt;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(ADDR_OSC_CTL, opt ? CTL_RESET : (CTL_RESET | 8'h04));
        rd(ADDR_CLK_DIV, opt ? DIV_RESET : DIV_RESET_LP);
        chk(16'(sysClkDivEn), 16'(!opt));
        ticks(32, opt ? 32 : 4);
    endtask : scn_reset_values

    task automatic scn_lock();
        wr(ADDR_CLK_DIV, 8'h55);
        rd(ADDR_CLK_DIV, DIV_RESET);
        wr(ADDR_OSC_CTL, 8'h00);
        rd(ADDR_OSC_CTL, CTL_RESET);
        wr(ADDR_OSC_CTL, UNLOCK_KEY1);
        wr(ADDR_CLK_DIV, 8'h11);
        wr(ADDR_OSC_CTL, UNLOCK_KEY2);
        wr(ADDR_CLK_DIV, 8'h22);
        rd(ADDR_CLK_DIV, DIV_RESET);
        wr(ADDR_OSC_CTL, UNLOCK_KEY1);
        rd(ADDR_OSC_CTL, CTL_RESET);
        wr(ADDR_OSC_CTL, UNLOCK_KEY2);
        wr(ADDR_CLK_DIV, 8'h03);
        rd(ADDR_CLK_DIV, 8'h03);
        wr(ADDR_CLK_DIV, 8'h44);
        rd(ADDR_CLK_DIV, 8'h03);
        rd(24'hFF_E0A2, 8'h00);
        chk(16'(sysClkDivEn), 16'h0001);
        ticks(30, 10);
    endtask : scn_lock

    task automatic scn_source();
        logic [7:0] tbl [4];
        tbl = '{8'hA0, 8'hC1, 8'hA2, 8'hE3};
        for (int i = 0; i < 4; i++) begin
            unlock();
            wr(ADDR_OSC_CTL, tbl[i]);
            #1;
            chk(16'(clockSourceSelect), 16'(tbl[i][1:0]));
            chk(16'({ipoEnable, xtalEnable, watchdogOscRun}), 16'(tbl[i][7:5]));
            rd(ADDR_OSC_CTL, tbl[i]);
        end
    endtask : scn_source

    task automatic scn_primary_fail();
        unlock();
        wr(ADDR_OSC_CTL, 8'hB0);
        #1;
        chk(16'(primaryRecoveryEnable), 16'h0001);
        @(posedge clk_sys);
        primaryOscFail <= 1'b1;
        repeat (4) @(posedge clk_sys);
        primaryOscFail <= 1'b0;
        #1;
        chk(16'(primaryRecoveryEnable), 16'h0000);
        rd(ADDR_OSC_CTL, 8'hA0);
    endtask : scn_primary_fail

    task automatic scn_watchdog_fail();
        int n;
        int ev;
        unlock();
        wr(ADDR_OSC_CTL, 8'hA8);
        n = 0;
        while (watchdogFailEvent !== 1'b1 && n < 8100) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 8100) begin
            mismatches++;
            report_and_stop();
        end
        chk(16'(n >= 7992 && n <= 8008), 16'h0001);
        rd(ADDR_OSC_CTL, CTL_RESET);
        ev = 0;
        repeat (8100) begin
            @(posedge clk_sys);
            #1;
            if (watchdogFailEvent === 1'b1) ev++;
        end
        chk(16'(ev), 16'h0000);
        unlock();
        wr(ADDR_OSC_CTL, 8'hA8);
        repeat (6000) @(posedge clk_sys);
        watchdogClkIn <= 1'b1;
        n = 0;
        while (watchdogFailEvent !== 1'b1 && n < 8100) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk(16'(n >= WDF_CYCLES && n <= WDF_CYCLES + 8), 16'h0001);
    endtask : scn_watchdog_fail

    task automatic scn_flash();
        scn_reset_values(1'b0);
        fl(1'b1, 1'b0, 1'b0);
        fl(1'b1, 1'b1, 1'b1);
        fl(1'b0, 1'b0, 1'b1);
    endtask : scn_flash

    initial begin
        scn_reset_values(1'b1);
        fl(1'b1, 1'b0, 1'b1);
        scn_lock();
        scn_source();
        scn_primary_fail();
        scn_watchdog_fail();
        scn_flash();
        report_and_stop();
    end
endmodule : oscsd_core_tb_top
`default_nettype wire
